//--- gpp_port.sv
// multipurpose general pin port: mode, direction and data registers over 32 pins
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module gpp_port
   import gpp_pkg::*;
(
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic resetn, // power-on reset, async, active low
   input wire logic watchdog_reset, // watchdog timer reset, sync, high
   input wire logic bus_override_strap_n, // override strap, low enables
   input wire logic [AW-1:0] reg_addr, // register byte address
   input wire logic [DW-1:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [DW-1:0] reg_rdata_q, // read data, cycle after strobe
   input wire logic [NPINS-1:0] pin_in, // pad input levels
   output logic [NPINS-1:0] pin_out_q, // pad output levels
   output logic [NPINS-1:0] pin_oe_n_q, // pad output enables, low drives
   output logic [NPINS-1:0] pull_up_q, // weak pullup enables
   output logic [NPINS-1:0] pull_dn_q, // weak pulldown enables
   input wire logic [NPINS-1:0] func_out, // normal function output levels
   input wire logic [NPINS-1:0] func_oe // normal function drive, high drives
);

   function automatic logic [31:0] put_half(input logic [31:0] v, input logic hi,
                                            input logic [15:0] w);
      logic [31:0] r;
      r = v;
      if (hi)
      begin
         r[31:16] = w;
      end
      else
      begin
         r[15:0] = w;
      end
      return r;
   endfunction

   function automatic logic [15:0] get_half(input logic [31:0] v, input logic hi);
      return hi ? v[31:16] : v[15:0];
   endfunction

   logic [31:0] mode_q, mode_d;
   logic [31:0] dir_q, dir_d;
   logic [31:0] data_q, data_d;
   logic por_done_q;
   logic [31:0] sync1_q, sync2_q;
   logic [15:0] rdata_d;

   // configuration decode per pin
   wire [31:0] gen_out_w = mode_q & ~dir_q;
   wire [31:0] in_nopull_w = mode_q & dir_q;
   wire [31:0] in_pull_w = ~mode_q & dir_q;
   wire [31:0] normal_w = ~mode_q & ~dir_q;

   // register port decode; writes wait out the strap cycle and watchdog reset
   wire bus_ok = por_done_q & ~watchdog_reset;
   wire wr_ok = reg_wr & bus_ok;
   wire sel_mode_lo = (reg_addr == ADDR_MODE_LO);
   wire sel_mode_hi = (reg_addr == ADDR_MODE_HI);
   wire sel_dir_lo = (reg_addr == ADDR_DIR_LO);
   wire sel_dir_hi = (reg_addr == ADDR_DIR_HI);
   wire sel_data_lo = (reg_addr == ADDR_DATA_LO);
   wire sel_data_hi = (reg_addr == ADDR_DATA_HI);
   wire wr_mode = wr_ok & (sel_mode_lo | sel_mode_hi);
   wire wr_dir = wr_ok & (sel_dir_lo | sel_dir_hi);
   wire wr_data = wr_ok & (sel_data_lo | sel_data_hi);
   wire strap_now = ~por_done_q & ~bus_override_strap_n;

   // strap caught on the first edge after release, never under the async reset
   assign mode_d = strap_now ? (mode_q & ~CLKSEL_MASK)
                 : wr_mode ? put_half(mode_q, sel_mode_hi, reg_wdata) : mode_q;
   assign dir_d = strap_now ? (dir_q & ~CLKSEL_MASK)
                : wr_dir ? put_half(dir_q, sel_dir_hi, reg_wdata) : dir_q;
   assign data_d = wr_data ? put_half(data_q, sel_data_hi, reg_wdata) : data_q;

   // output drivers: normal function only reaches pins not in general mode
   wire [31:0] pin_out_d = (mode_q & data_q) | (~mode_q & func_out);
   wire [31:0] pin_oe_n_d = ~(gen_out_w | (normal_w & func_oe));
   wire [31:0] pull_up_d = in_pull_w & PULL_UP_MAP;
   wire [31:0] pull_dn_d = in_pull_w & ~PULL_UP_MAP;

   // outputs read back their data bit, everything else the synced pin
   wire [31:0] data_view = (gen_out_w & data_q) | (~gen_out_w & sync2_q);
   wire [15:0] rd_mux =
      (sel_mode_lo | sel_mode_hi) ? get_half(mode_q, sel_mode_hi) :
      (sel_dir_lo | sel_dir_hi) ? get_half(dir_q, sel_dir_hi) :
      (sel_data_lo | sel_data_hi) ? get_half(data_view, sel_data_hi) : ZERO16;
   assign rdata_d = (reg_rd & bus_ok) ? rd_mux : ZERO16;

   // watchdog reset is not wired here on purpose, so it cannot touch the setup
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_q <= MODE_RST;
         dir_q <= DIR_RST;
         data_q <= DATA_RST;
         por_done_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         dir_q <= dir_d;
         data_q <= data_d;
         por_done_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_q <= PINS_LOW;
         sync2_q <= PINS_LOW;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_out_q <= PINS_LOW;
         pin_oe_n_q <= PINS_HIGH;
         pull_up_q <= PINS_LOW;
         pull_dn_q <= PINS_LOW;
         reg_rdata_q <= ZERO16;
      end
      else
      begin
         pin_out_q <= pin_out_d;
         pin_oe_n_q <= pin_oe_n_d;
         pull_up_q <= pull_up_d;
         pull_dn_q <= pull_dn_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_por_first;
      !por_done_q;
   endsequence

   sequence s_write_mode_lo;
      reg_wr && bus_ok && sel_mode_lo;
   endsequence

   property p_mode_write;
      logic [15:0] w;
      (s_write_mode_lo, w = reg_wdata) |=> (mode_q[15:0] == w);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode write not stored");

   property p_general_ignores_func;
      ((pin_out_q ^ $past(data_q)) & $past(mode_q)) == 32'h0000_0000;
   endproperty
   a_general_ignores_func: assert property (p_general_ignores_func)
      else $error("normal function leaked onto general pin");

   property p_pull_cfg;
      ((pull_up_q | pull_dn_q) & ~$past(in_pull_w)) == 32'h0000_0000
         && (pull_up_q & pull_dn_q) == 32'h0000_0000;
   endproperty
   a_pull_cfg: assert property (p_pull_cfg)
      else $error("pull enabled outside pulled input");

   property p_open_drain;
      (($past(in_nopull_w) & ~pin_oe_n_q) == 32'h0000_0000)
         && (($past(gen_out_w) & pin_oe_n_q) == 32'h0000_0000);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("direction bit does not steer the driver");

   property p_por_defaults;
      s_por_first |-> (mode_q == MODE_RST) && (dir_q == DIR_RST) && (data_q == DATA_RST);
   endproperty
   a_por_defaults: assert property (p_por_defaults)
      else $error("power-on defaults wrong");

   property p_watchdog_keeps;
      watchdog_reset |=> $stable(mode_q) && $stable(dir_q) && $stable(data_q);
   endproperty
   a_watchdog_keeps: assert property (p_watchdog_keeps)
      else $error("watchdog reset changed pin setup");

   property p_upper_addr_normal;
      s_por_first |=> ((mode_q | dir_q) & UPPER_ADDR_MASK) == 32'h0000_0000;
   endproperty
   a_upper_addr_normal: assert property (p_upper_addr_normal)
      else $error("upper address pins not normal after reset");

   property p_bus_ctrl_normal;
      s_por_first |=> ((mode_q | dir_q) & BUS_CTRL_MASK) == 32'h0000_0000;
   endproperty
   a_bus_ctrl_normal: assert property (p_bus_ctrl_normal)
      else $error("bus control pins not normal after reset");

   property p_strap;
      s_por_first |=> (((mode_q | dir_q) & CLKSEL_MASK) == 32'h0000_0000)
         == !$past(bus_override_strap_n);
   endproperty
   a_strap: assert property (p_strap)
      else $error("clock-select pins ignore the override strap");

   property p_read_input;
      (reg_rd && bus_ok && sel_data_lo && (gen_out_w[15:0] == ZERO16))
         |=> (reg_rdata_q == $past(sync2_q[15:0]));
   endproperty
   a_read_input: assert property (p_read_input)
      else $error("input read does not show synced pin");

   sequence s_write_dir_hi;
      reg_wr && bus_ok && sel_dir_hi;
   endsequence

   sequence s_write_data_lo;
      reg_wr && bus_ok && sel_data_lo;
   endsequence

   sequence s_write_data_hi;
      reg_wr && bus_ok && sel_data_hi;
   endsequence

   sequence s_read_data_hi;
      reg_rd && bus_ok && sel_data_hi;
   endsequence

   property p_dir_write;
      logic [15:0] w;
      (s_write_dir_hi, w = reg_wdata) |=> (dir_q[31:16] == w);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write not stored");

   property p_data_write;
      logic [15:0] w;
      (s_write_data_lo, w = reg_wdata) |=> (data_q[15:0] == w);
   endproperty
   a_data_write: assert property (p_data_write)
      else $error("data write not stored");

   property p_read_output;
      s_read_data_hi |=> ((reg_rdata_q ^ $past(data_q[31:16]))
         & $past(gen_out_w[31:16])) == ZERO16;
   endproperty
   a_read_output: assert property (p_read_output)
      else $error("output read does not show data bit");

   property p_read_input_hi;
      s_read_data_hi |=> ((reg_rdata_q ^ $past(sync2_q[31:16]))
         & ~$past(gen_out_w[31:16])) == ZERO16;
   endproperty
   a_read_input_hi: assert property (p_read_input_hi)
      else $error("upper input read does not show synced pin");

   property p_rdata_idle;
      !reg_rd |=> reg_rdata_q == ZERO16;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data present without a read");

   property p_watchdog_read;
      watchdog_reset |=> reg_rdata_q == ZERO16;
   endproperty
   a_watchdog_read: assert property (p_watchdog_read)
      else $error("read answered during watchdog reset");

   property p_normal_passes;
      por_done_q |-> (((pin_out_q ^ $past(func_out)) & ~$past(mode_q)) == 32'h0000_0000)
         && (((~pin_oe_n_q ^ $past(func_oe)) & $past(normal_w)) == 32'h0000_0000);
   endproperty
   a_normal_passes: assert property (p_normal_passes)
      else $error("normal function lost on a normal pin");

   property p_pull_dir;
      por_done_q |-> (pull_up_q == ($past(in_pull_w) & PULL_UP_MAP))
         && (pull_dn_q == ($past(in_pull_w) & ~PULL_UP_MAP));
   endproperty
   a_pull_dir: assert property (p_pull_dir)
      else $error("pull direction wrong on pulled input");

   property p_mode_hold;
      (por_done_q && !(reg_wr && (sel_mode_lo || sel_mode_hi))) |=> $stable(mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed without a mode write");

   property p_dir_hold;
      (por_done_q && !(reg_wr && (sel_dir_lo || sel_dir_hi))) |=> $stable(dir_q);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("direction changed without a direction write");

   property p_por_others_kept;
      s_por_first |=> (((mode_q ^ MODE_RST) | (dir_q ^ DIR_RST)) & ~CLKSEL_MASK)
         == 32'h0000_0000;
   endproperty
   a_por_others_kept: assert property (p_por_others_kept)
      else $error("strap edge disturbed other pins");

endmodule
`default_nettype wire

//--- gpp_pkg.sv
// constants for the multipurpose general pin port
package gpp_pkg;
   localparam int NPINS = 32;
   localparam int HALF = 16;
   localparam int AW = 8;
   localparam int DW = 16;

   // register byte addresses, one 16-bit half of the pin set each
   localparam logic [7:0] ADDR_MODE_LO = 8'h00;
   localparam logic [7:0] ADDR_DIR_LO = 8'h04;
   localparam logic [7:0] ADDR_DATA_LO = 8'h08;
   localparam logic [7:0] ADDR_MODE_HI = 8'h0C;
   localparam logic [7:0] ADDR_DIR_HI = 8'h10;
   localparam logic [7:0] ADDR_DATA_HI = 8'h14;

   // pin positions of the pins with a fixed or strap-chosen power-on setup
   localparam int PIN_UPPER_ADDR17 = 7;
   localparam int PIN_UPPER_ADDR18 = 8;
   localparam int PIN_UPPER_ADDR19 = 9;
   localparam int PIN_BUS_DIRECTION = 4;
   localparam int PIN_DATA_ENABLE = 5;
   localparam int PIN_SYNC_READY = 6;
   localparam int PIN_STATUS6_CLKSEL2 = 29;
   localparam int PIN_UPPER_HALF_CLKSEL1 = 26;

   localparam logic [31:0] ONE32 = 32'h0000_0001;
   localparam logic [31:0] UPPER_ADDR_MASK = (ONE32 << PIN_UPPER_ADDR17)
      | (ONE32 << PIN_UPPER_ADDR18) | (ONE32 << PIN_UPPER_ADDR19);
   localparam logic [31:0] BUS_CTRL_MASK = (ONE32 << PIN_BUS_DIRECTION)
      | (ONE32 << PIN_DATA_ENABLE) | (ONE32 << PIN_SYNC_READY);
   localparam logic [31:0] CLKSEL_MASK = (ONE32 << PIN_STATUS6_CLKSEL2)
      | (ONE32 << PIN_UPPER_HALF_CLKSEL1);

   // power-on setup: mode 0 everywhere, direction 1 except normal-use pins
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [31:0] DIR_RST = ~(UPPER_ADDR_MASK | BUS_CTRL_MASK);
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   // which pulled inputs pull up; the rest pull down
   localparam logic [31:0] PULL_UP_MAP = 32'hFFFF_0F0F | CLKSEL_MASK;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [31:0] PINS_LOW = 32'h0000_0000;
   localparam logic [31:0] PINS_HIGH = 32'hFFFF_FFFF;
endpackage

//--- gpp_board.sv
// board-side pad model: device drive, board drive, weak pulls
`timescale 1ns/10ps
`default_nettype none
module gpp_board
   import gpp_pkg::*;
(
   input wire logic clk_sys, // clock for the floating pattern
   input wire logic [NPINS-1:0] pin_out_q, // device pad level
   input wire logic [NPINS-1:0] pin_oe_n_q, // device drives when low
   input wire logic [NPINS-1:0] pull_up_q, // weak pullup on
   input wire logic [NPINS-1:0] pull_dn_q, // weak pulldown on
   input wire logic [NPINS-1:0] ext_val, // board drive level
   input wire logic [NPINS-1:0] ext_en, // board drives when high
   output logic [NPINS-1:0] pad // resolved pad level
);
   logic [NPINS-1:0] float_q = 32'h5555_5555;
   // a floating unpulled pad must not look steady
   always @(posedge clk_sys)
      float_q <= ~float_q;
   always_comb
      pad = (~pin_oe_n_q & pin_out_q) | (pin_oe_n_q & ext_en & ext_val)
         | (pin_oe_n_q & ~ext_en & (pull_up_q | (~pull_dn_q & float_q)));
endmodule
`default_nettype wire

//--- tb_gpp_port.sv
// self-checking bench for the general pin port
`timescale 1ns/10ps
`default_nettype none
module tb_gpp_port;
   import gpp_pkg::*;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic watchdog_reset = 1'h0;
   logic bus_override_strap_n = 1'h1;
   logic [AW-1:0] reg_addr = 8'h0;
   logic [DW-1:0] reg_wdata = 16'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [NPINS-1:0] func_out = 32'h0, func_oe = 32'h0, ext_val = 32'h0, ext_en = 32'h0;
   logic [DW-1:0] reg_rdata_q;
   logic [NPINS-1:0] pin_in, pin_out_q, pin_oe_n_q, pull_up_q, pull_dn_q;
   logic [31:0] mdl [3];
   logic [31:0] e_oen, e_out, e_pu, e_pd, e_lvl, e_det;
   logic [31:0] rnd = 32'hFA1B;
   logic [15:0] rv;
   logic [7:0] adr [6] = '{ADDR_MODE_LO, ADDR_DIR_LO, ADDR_DATA_LO,
      ADDR_MODE_HI, ADDR_DIR_HI, ADDR_DATA_HI};
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   gpp_port gpp_port_i (.clk_sys, .resetn, .watchdog_reset, .bus_override_strap_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pin_in, .pin_out_q, .pin_oe_n_q,
      .pull_up_q, .pull_dn_q, .func_out, .func_oe);
   gpp_board gpp_board_i (.clk_sys, .pin_out_q, .pin_oe_n_q, .pull_up_q, .pull_dn_q,
      .ext_val, .ext_en, .pad(pin_in));
   always #5 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g, m);
      n_tests++;
      if (((e ^ g) & m) !== 32'h0)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e & m, g);
      end
   endtask
   task automatic wr(input int r, input logic [15:0] v, input bit upd);
      @(posedge clk_sys);
      reg_addr <= adr[r];
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      if (upd)
         mdl[r % 3][(r / 3) * 16 +: 16] = v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 d = reg_rdata_q;
   endtask
   task automatic por(input logic s);
      @(posedge clk_sys);
      resetn <= 1'h0;
      bus_override_strap_n <= s;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'h1;
      // first edge after release ignores the bus
      repeat (3) @(posedge clk_sys);
      bus_override_strap_n <= 1'h1;
      mdl[0] = MODE_RST;
      mdl[1] = s ? DIR_RST : DIR_RST & ~CLKSEL_MASK;
      mdl[2] = DATA_RST;
   endtask
   task automatic check_all(input string nm);
      logic [31:0] od, ev, mk;
      logic [15:0] got;
      int h;
      // two-flop input sync needs settling time before reads
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < NPINS; i++)
         case ({mdl[0][i], mdl[1][i]})
            2'h0: {e_oen[i], e_out[i], e_pu[i], e_pd[i]} = {~func_oe[i], func_out[i], 2'h0};
            2'h1: {e_oen[i], e_out[i], e_pu[i], e_pd[i]} = {2'h2, PULL_UP_MAP[i], ~PULL_UP_MAP[i]};
            2'h2: {e_oen[i], e_out[i], e_pu[i], e_pd[i]} = {1'h0, mdl[2][i], 2'h0};
            default: {e_oen[i], e_out[i], e_pu[i], e_pd[i]} = 4'h8;
         endcase
      e_lvl = (~e_oen & e_out) | (e_oen & ext_en & ext_val) | (e_oen & ~ext_en & e_pu);
      e_det = ~e_oen | ext_en | e_pu | e_pd;
      chk("pin_oe_n_q", e_oen, pin_oe_n_q, 32'hFFFF_FFFF);
      chk("pin_out_q", e_out, pin_out_q, ~e_oen);
      chk("pull_up_q", e_pu, pull_up_q, 32'hFFFF_FFFF);
      chk("pull_dn_q", e_pd, pull_dn_q, 32'hFFFF_FFFF);
      od = mdl[0] & ~mdl[1];
      for (int r = 0; r < 6; r++)
      begin
         h = (r / 3) * 16;
         ev = (r % 3 == 2) ? ((od & mdl[2]) | (~od & e_lvl)) : mdl[r % 3];
         mk = (r % 3 == 2) ? (od | e_det) : 32'hFFFF_FFFF;
         rd(adr[r], got);
         chk("reg_rdata_q", {16'h0, ev[h +: 16]}, {16'h0, got}, {16'h0, mk[h +: 16]});
      end
      $display("test %s done", nm);
   endtask
   initial
   begin
      por(1'h1);
      check_all("power_on");
      for (int k = 0; k < 24; k++)
      begin
         for (int r = 0; r < 6; r++)
         begin
            rnd = lfsr(rnd);
            wr(r, rnd[15:0], 1'h1);
         end
         rnd = lfsr(rnd);
         func_out <= rnd;
         func_oe <= {rnd[15:0], rnd[31:16]};
         ext_val <= ~rnd;
         ext_en <= rnd ^ {rnd[7:0], rnd[31:8]};
         check_all("random");
      end
      wr(2, 16'h0, 1'h1);
      wr(0, 16'hFFFF, 1'h1);
      for (int k = 0; k < 3; k++)
      begin
         rnd = lfsr(rnd);
         wr(1, rnd[15:0], 1'h1);
         check_all("open_drain");
      end
      @(posedge clk_sys);
      watchdog_reset <= 1'h1;
      wr(0, 16'h1234, 1'h0);
      wr(5, 16'hA5A5, 1'h0);
      watchdog_reset <= 1'h0;
      check_all("watchdog");
      rd(8'h20, rv);
      chk("unmapped", 32'h0, {16'h0, rv}, 32'hFFFF);
      por(1'h0);
      check_all("strap_override");
      finish_test();
   end
endmodule
`default_nettype wire
